// *** common/tpd_consts.svh ***
`ifndef TPD_CONSTS_SVH
`define TPD_CONSTS_SVH

`define TPD_ADDR_W          16
`define TPD_DATA_W          4
`define TPD_ADDR_MODE       16'hff10
`define TPD_ADDR_PAUSE      16'hff15
`define TPD_ADDR_DIGIT      16'hff17
`define TPD_ADDR_HOOK       16'hff18
`define TPD_ADDR_IRQ        16'hfff9

`define TPD_MODE_TPS_BIT    3
`define TPD_MODE_DRS_BIT    2
`define TPD_MODE_MB_BIT     1
`define TPD_HOOK_ON_BIT     3
`define TPD_HOOK_RXEN_BIT   1
`define TPD_HOOK_TXEN_BIT   0
`define TPD_IRQ_FLAG_BIT    0
`define TPD_IRQ_BUSY_BIT    1

`define TPD_PAUSE_RESET     4'h8
`define TPD_DIGIT_RESET     4'h0
`define TPD_MAX_CODE        15

`define TPD_OSC_HZ          32768
`define TPD_RATE_SLOW_PPS   10
`define TPD_RATE_FAST_PPS   20
`define TPD_MAKE40_PERMIL   400
`define TPD_MAKE33_PERMIL   333
`define TPD_PERMIL          1000
`define TPD_PAUSE_STEP      3072
`define TPD_MUTE_HOLD_US    4000
`define TPD_US_PER_S        1000000
`define TPD_TIMER_W         16
`endif

// *** common/tpd_pkg.sv ***
package tpd_pkg;
  typedef enum logic [2:0] {
    TPD_IDLE,
    TPD_BREAK,
    TPD_MAKE,
    TPD_PAUSE,
    TPD_HOLD
  } tpd_state_e;
  typedef logic [3:0] tpd_nib_t;
endpackage

// *** common/tpd_cnt_if.sv ***
interface tpd_cnt_if;
  logic       tick;
  logic       load;
  logic [3:0] loadVal;
  logic       dec;
  logic       zero;
  modport ctl (input tick, output load, output loadVal, output dec, input zero);
  modport cnt (input load, input loadVal, input dec, output zero);
  modport osc (output tick);
endinterface

// *** hdl/tpd_osc_tick.sv ***
module tpd_osc_tick
  import tpd_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic lowSpeedOsc,
  tpd_cnt_if.osc    tk
);
  logic oscPrev_r;
  logic tick_r;

  // one tick per rising edge of the 32 kHz oscillator
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oscPrev_r <= 1'b0;
      tick_r    <= 1'b0;
    end else begin
      oscPrev_r <= lowSpeedOsc;
      tick_r    <= lowSpeedOsc & ~oscPrev_r;
    end
  end

  assign tk.tick = tick_r;
endmodule

// *** hdl/tpd_down_counter.sv ***
module tpd_down_counter
  import tpd_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic mclk,
  input  wire logic rst,
  tpd_cnt_if.cnt    c
);
  // refused at elaboration: the counter is preset straight from the digit
  if (CNT_W != $bits(tpd_nib_t)) begin
    $error("down counter must match the 4-bit digit code");
  end

  logic [CNT_W-1:0] count_r;

  // load wins over a decrement in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (c.load) begin
      count_r <= c.loadVal;
    end else if (c.dec && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign c.zero = (count_r == '0);
endmodule

// *** hdl/tpd_pulse_dialer.sv ***
`include "tpd_consts.svh"
module tpd_pulse_dialer
  import tpd_pkg::*;
#(
  parameter int OSC_HZ     = `TPD_OSC_HZ,
  parameter int PAUSE_STEP = `TPD_PAUSE_STEP
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    lowSpeedOsc,
  input  wire logic [`TPD_ADDR_W-1:0]  addr,
  input  wire logic [`TPD_DATA_W-1:0]  wrData,
  input  wire logic                    wrStb,
  input  wire logic                    rdStb,
  output logic      [`TPD_DATA_W-1:0]  rdData,
  output logic                         dialPulseOutN,
  output logic                         receiveMuteN,
  output logic                         transmitMuteN,
  output logic                         dialIrq
);
  localparam int TW = `TPD_TIMER_W;
  localparam int SLOW_PER  = OSC_HZ / `TPD_RATE_SLOW_PPS;
  localparam int FAST_PER  = OSC_HZ / `TPD_RATE_FAST_PPS;
  localparam int SLOW_M40  = OSC_HZ * `TPD_MAKE40_PERMIL / (`TPD_PERMIL * `TPD_RATE_SLOW_PPS);
  localparam int SLOW_M33  = OSC_HZ * `TPD_MAKE33_PERMIL / (`TPD_PERMIL * `TPD_RATE_SLOW_PPS);
  localparam int FAST_M40  = OSC_HZ * `TPD_MAKE40_PERMIL / (`TPD_PERMIL * `TPD_RATE_FAST_PPS);
  localparam int FAST_M33  = OSC_HZ * `TPD_MAKE33_PERMIL / (`TPD_PERMIL * `TPD_RATE_FAST_PPS);
  // least time: round up to whole ticks
  localparam int HOLD_TK   = (`TPD_MUTE_HOLD_US * OSC_HZ + `TPD_US_PER_S - 1) / `TPD_US_PER_S;
  localparam int MAX_CODE  = `TPD_MAX_CODE;

  // refused at elaboration: the timer must hold the longest pause and period
  if (PAUSE_STEP < 1 || PAUSE_STEP * MAX_CODE >= (1 << TW)) begin
    $error("pause step does not fit the timer");
  end
  if (SLOW_PER >= (1 << TW) || FAST_M33 < 2 || HOLD_TK < 1) begin
    $error("oscillator rate unsupported");
  end

  localparam logic [TW-1:0] S_MAKE40 = TW'(SLOW_M40 - 1);
  localparam logic [TW-1:0] S_MAKE33 = TW'(SLOW_M33 - 1);
  localparam logic [TW-1:0] F_MAKE40 = TW'(FAST_M40 - 1);
  localparam logic [TW-1:0] F_MAKE33 = TW'(FAST_M33 - 1);
  localparam logic [TW-1:0] S_BRK40  = TW'(SLOW_PER - SLOW_M40 - 1);
  localparam logic [TW-1:0] S_BRK33  = TW'(SLOW_PER - SLOW_M33 - 1);
  localparam logic [TW-1:0] F_BRK40  = TW'(FAST_PER - FAST_M40 - 1);
  localparam logic [TW-1:0] F_BRK33  = TW'(FAST_PER - FAST_M33 - 1);
  localparam logic [TW-1:0] HOLD_LD  = TW'(HOLD_TK - 1);
  localparam logic [TW-1:0] STEP     = TW'(PAUSE_STEP);

  tpd_cnt_if cif ();

  tpd_osc_tick u_tick (
    .mclk        (mclk),
    .rst         (rst),
    .lowSpeedOsc (lowSpeedOsc),
    .tk          (cif.osc)
  );

  tpd_down_counter #(.CNT_W(`TPD_DATA_W)) u_cnt (
    .mclk (mclk),
    .rst  (rst),
    .c    (cif.cnt)
  );

  // register file
  logic     pulseMode_r;
  logic     rateFast_r;
  logic     ratio33_r;
  tpd_nib_t pauseCode_r;
  tpd_nib_t digitCode_r;
  logic     hookOn_r;
  logic     rxEn_r;
  logic     txEn_r;
  logic     irqFlag_r;

  logic wrMode;
  logic wrPause;
  logic wrDigit;
  logic wrHook;
  logic wrIrq;
  assign wrMode  = wrStb && addr == `TPD_ADDR_MODE;
  assign wrPause = wrStb && addr == `TPD_ADDR_PAUSE;
  assign wrDigit = wrStb && addr == `TPD_ADDR_DIGIT;
  assign wrHook  = wrStb && addr == `TPD_ADDR_HOOK;
  assign wrIrq   = wrStb && addr == `TPD_ADDR_IRQ;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulseMode_r <= 1'b0;
      rateFast_r  <= 1'b0;
      ratio33_r   <= 1'b0;
    end else if (wrMode) begin
      pulseMode_r <= wrData[`TPD_MODE_TPS_BIT];
      rateFast_r  <= wrData[`TPD_MODE_DRS_BIT];
      ratio33_r   <= wrData[`TPD_MODE_MB_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pauseCode_r <= `TPD_PAUSE_RESET;
    end else if (wrPause) begin
      pauseCode_r <= wrData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      digitCode_r <= `TPD_DIGIT_RESET;
    end else if (wrDigit) begin
      digitCode_r <= wrData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hookOn_r <= 1'b0;
      rxEn_r   <= 1'b0;
      txEn_r   <= 1'b0;
    end else if (wrHook) begin
      hookOn_r <= wrData[`TPD_HOOK_ON_BIT];
      rxEn_r   <= wrData[`TPD_HOOK_RXEN_BIT];
      txEn_r   <= wrData[`TPD_HOOK_TXEN_BIT];
    end
  end

  // dialing sequencer
  tpd_state_e      state_r;
  tpd_state_e      state_nxt;
  logic [TW-1:0]   timer_r;
  logic [TW-1:0]   timer_nxt;
  logic            timerLoad;
  logic            expire;
  logic            start;
  logic            pauseDone;
  logic [TW-1:0]   breakLd;
  logic [TW-1:0]   makeLd;
  logic [TW-1:0]   pauseLd;

  // in tone mode the digit write is only stored in the digit register, so nothing starts here
  assign start     = wrDigit && pulseMode_r && hookOn_r;
  assign expire    = cif.tick && timer_r == '0;
  assign pauseDone = state_r == TPD_PAUSE && expire;
  assign breakLd   = rateFast_r ? (ratio33_r ? F_BRK33 : F_BRK40)
                                : (ratio33_r ? S_BRK33 : S_BRK40);
  assign makeLd    = rateFast_r ? (ratio33_r ? F_MAKE33 : F_MAKE40)
                                : (ratio33_r ? S_MAKE33 : S_MAKE40);
  assign pauseLd   = TW'(pauseCode_r * STEP) - 1'b1;

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    timerLoad = 1'b0;
    if (!hookOn_r) begin
      // going on-hook abandons any digit in flight
      state_nxt = TPD_IDLE;
    end else if (start) begin
      state_nxt = TPD_BREAK;
      timer_nxt = breakLd;
      timerLoad = 1'b1;
    end else if (expire) begin
      timerLoad = 1'b1;
      unique case (state_r)
        TPD_IDLE: begin
          timerLoad = 1'b0;
        end
        TPD_BREAK: begin
          state_nxt = TPD_MAKE;
          timer_nxt = makeLd;
        end
        TPD_MAKE: begin
          if (cif.zero) begin
            state_nxt = TPD_PAUSE;
            timer_nxt = pauseLd;
          end else begin
            state_nxt = TPD_BREAK;
            timer_nxt = breakLd;
          end
        end
        TPD_PAUSE: begin
          state_nxt = TPD_HOLD;
          timer_nxt = HOLD_LD;
        end
        TPD_HOLD: begin
          state_nxt = TPD_IDLE;
          timerLoad = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= TPD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_r <= '0;
    end else if (timerLoad) begin
      timer_r <= timer_nxt;
    end else if (cif.tick && timer_r != '0) begin
      timer_r <= timer_r - 1'b1;
    end
  end

  // counter is preset on start, stepped at the end of each break
  assign cif.load    = start;
  assign cif.loadVal = wrData;
  assign cif.dec     = state_r == TPD_BREAK && expire && hookOn_r && !start;

  // flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqFlag_r <= 1'b0;
    end else if (pauseDone && hookOn_r && !start) begin
      irqFlag_r <= 1'b1;
    end else if (wrIrq && wrData[`TPD_IRQ_FLAG_BIT]) begin
      irqFlag_r <= 1'b0;
    end
  end

  // pins, all straight from flops
  logic muteNxt;
  assign muteNxt = state_nxt != TPD_IDLE;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dialPulseOutN <= 1'b0;
      receiveMuteN  <= 1'b1;
      transmitMuteN <= 1'b1;
      dialIrq       <= 1'b0;
    end else begin
      dialPulseOutN <= hookOn_r && state_nxt != TPD_BREAK;
      receiveMuteN  <= !(muteNxt && rxEn_r);
      transmitMuteN <= !(muteNxt && txEn_r);
      dialIrq       <= irqFlag_r;
    end
  end

  // read port: data stand in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdStb) begin
      unique case (addr)
        `TPD_ADDR_MODE:  rdData <= {pulseMode_r, rateFast_r, ratio33_r, 1'b0};
        `TPD_ADDR_PAUSE: rdData <= pauseCode_r;
        `TPD_ADDR_DIGIT: rdData <= digitCode_r;
        `TPD_ADDR_HOOK:  rdData <= {hookOn_r, 1'b0, rxEn_r, txEn_r};
        `TPD_ADDR_IRQ:   rdData <= {2'b00, state_r != TPD_IDLE, irqFlag_r};
        default:         rdData <= '0;
      endcase
    end else begin
      rdData <= '0;
    end
  end

  // helper: break count within one digit
  logic [4:0] breaks_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      breaks_r <= '0;
    end else if (start) begin
      breaks_r <= '0;
    end else if (state_r == TPD_BREAK && state_nxt == TPD_MAKE) begin
      breaks_r <= breaks_r + 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  start_break_a: assert property (start |=> state_r == TPD_BREAK && !dialPulseOutN)
    else $error("digit write did not start a break");
  mute_low_a: assert property (start && txEn_r && rxEn_r |=> !transmitMuteN && !receiveMuteN)
    else $error("mutes not pulled low on digit write");
  pulse_count_a: assert property (state_r == TPD_MAKE && state_nxt == TPD_PAUSE
      |-> breaks_r == {1'b0, digitCode_r})
    else $error("pulse count differs from digit code");
  break_len_a: assert property (state_r != TPD_BREAK && state_nxt == TPD_BREAK
      |=> timer_r == (rateFast_r ? (ratio33_r ? F_BRK33 : F_BRK40)
                                 : (ratio33_r ? S_BRK33 : S_BRK40)))
    else $error("break length wrong");
  make_len_a: assert property ($rose(state_r == TPD_MAKE)
      |-> timer_r == (rateFast_r ? (ratio33_r ? F_MAKE33 : F_MAKE40)
                                 : (ratio33_r ? S_MAKE33 : S_MAKE40)))
    else $error("make length wrong");
  pause_len_a: assert property ($rose(state_r == TPD_PAUSE)
      |-> timer_r == TW'(pauseCode_r * STEP) - 1'b1 && dialPulseOutN)
    else $error("pause length wrong or pin low");
  irq_raise_a: assert property (pauseDone && hookOn_r && !start |=> irqFlag_r ##1 dialIrq)
    else $error("pause end did not raise the flag");
  flag_keep_a: assert property (irqFlag_r && !(wrIrq && wrData[`TPD_IRQ_FLAG_BIT])
      |=> irqFlag_r)
    else $error("flag dropped without a clear");
  hold_end_a: assert property (state_r == TPD_HOLD && expire && hookOn_r && !start
      |=> state_r == TPD_IDLE && transmitMuteN && receiveMuteN)
    else $error("mutes not released after hold");
  tick_only_a: assert property (!cif.tick && !timerLoad |=> $stable(timer_r))
    else $error("timer moved without an oscillator tick");
  offhook_high_a: assert property (hookOn_r && state_nxt != TPD_BREAK |=> dialPulseOutN)
    else $error("dial pin not high off-hook");

  // tone mode leaves the sequencer alone; the digit is only stored
  tone_quiet_a: assert property (wrDigit && !pulseMode_r && state_r == TPD_IDLE
      |=> state_r == TPD_IDLE)
    else $error("digit write in tone mode started dialing");
  mode_write_a: assert property (wrMode
      |=> pulseMode_r == $past(wrData[`TPD_MODE_TPS_BIT])
          && rateFast_r == $past(wrData[`TPD_MODE_DRS_BIT])
          && ratio33_r == $past(wrData[`TPD_MODE_MB_BIT]))
    else $error("mode write not taken");
  digit_store_a: assert property (wrDigit |=> digitCode_r == $past(wrData))
    else $error("digit code not stored");
  break_low_a: assert property (state_r == TPD_BREAK |-> !dialPulseOutN)
    else $error("dial pin high during a break");
  next_break_a: assert property (state_r == TPD_MAKE && expire && !cif.zero
      && hookOn_r && !start |=> state_r == TPD_BREAK)
    else $error("pulses stopped before the counter ran out");
  pause_pin_a: assert property (state_r == TPD_PAUSE |-> dialPulseOutN)
    else $error("dial pin low during the pause");
  pause_exit_a: assert property (pauseDone && hookOn_r && !start |=> state_r == TPD_HOLD)
    else $error("pause end did not start the mute hold");
  hold_len_a: assert property ($rose(state_r == TPD_HOLD) |-> timer_r == HOLD_LD)
    else $error("mute hold length wrong");
  idle_mute_a: assert property (state_r == TPD_IDLE |-> receiveMuteN && transmitMuteN)
    else $error("mute held low while idle");

  // the flag moves only on a pause end or a software clear
  irq_quiet_a: assert property (!irqFlag_r && !(pauseDone && hookOn_r && !start)
      |=> !irqFlag_r)
    else $error("flag set without a pause end");
  flag_clear_a: assert property (wrIrq && wrData[`TPD_IRQ_FLAG_BIT]
      && !(pauseDone && hookOn_r && !start) |=> !irqFlag_r)
    else $error("flag not cleared by a write of one");

  // going on-hook abandons the digit at once, whatever phase it was in
  onhook_idle_a: assert property (!hookOn_r
      |=> state_r == TPD_IDLE && !dialPulseOutN && receiveMuteN && transmitMuteN)
    else $error("on-hook did not drop the line");
endmodule

// *** testbench/tpd_line_model.sv ***
module tpd_line_model (
  input  wire logic mclk,
  input  wire logic clr,
  input  wire logic dialPulseOutN,
  input  wire logic receiveMuteN,
  output int        pulses,
  output int        breakLen,
  output int        makeLen,
  output int        riseCyc,
  output int        muteUps,
  output int        cyc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pinQ;
  logic muteQ;
  int   fallCyc;
  // the line only listens: counts breaks and times make and break in mclk cycles
  initial begin
    pinQ = 1'b0;
    muteQ = 1'b1;
    fallCyc = 0;
    pulses = 0;
    breakLen = 0;
    makeLen = 0;
    riseCyc = 0;
    muteUps = 0;
    cyc = 0;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    pinQ <= dialPulseOutN;
    muteQ <= receiveMuteN;
    if (clr) begin
      pulses <= 0;
      muteUps <= 0;
    end else begin
      if (pinQ && !dialPulseOutN) begin
        pulses <= pulses + 1;
        fallCyc <= cyc;
        // make length only between two pulses, not after going off-hook
        if (pulses > 0) makeLen <= cyc - riseCyc;
      end
      if (!muteQ && receiveMuteN) muteUps <= muteUps + 1;
    end
    if (!pinQ && dialPulseOutN) begin
      breakLen <= cyc - fallCyc;
      riseCyc <= cyc;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
`include "tpd_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t got %0h expected %0h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tpd_pkg::*;
  // shrunk oscillator so a 15-pulse digit stays short; one tick every 4 mclk
  localparam int OSC  = 1000;
  localparam int STEP = 4;
  localparam int TK   = 4;
  localparam int HOLD = (OSC * `TPD_MUTE_HOLD_US + `TPD_US_PER_S - 1) / `TPD_US_PER_S;
  logic                   mclk = 1'b0;
  logic                   rst = 1'b1;
  logic                   lowSpeedOsc = 1'b0;
  logic [1:0]             oscDiv = 2'h0;
  logic [`TPD_ADDR_W-1:0] addr = 16'h0000;
  tpd_nib_t               wrData = 4'h0;
  logic                   wrStb = 1'b0;
  logic                   rdStb = 1'b0;
  logic                   clr = 1'b0;
  tpd_nib_t               rdData;
  logic                   dialPulseOutN;
  logic                   receiveMuteN;
  logic                   transmitMuteN;
  logic                   dialIrq;
  int                     pulses, breakLen, makeLen, riseCyc, muteUps, cyc;
  int                     failures = 0;
  int                     n_checks = 0;

  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    oscDiv <= oscDiv + 2'h1;
    lowSpeedOsc <= oscDiv[1];
  end

  tpd_pulse_dialer #(.OSC_HZ(OSC), .PAUSE_STEP(STEP)) u_dut (
    .mclk(mclk), .rst(rst), .lowSpeedOsc(lowSpeedOsc), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .dialPulseOutN(dialPulseOutN),
    .receiveMuteN(receiveMuteN), .transmitMuteN(transmitMuteN), .dialIrq(dialIrq));
  tpd_line_model u_line (
    .mclk(mclk), .clr(clr), .dialPulseOutN(dialPulseOutN), .receiveMuteN(receiveMuteN),
    .pulses(pulses), .breakLen(breakLen), .makeLen(makeLen), .riseCyc(riseCyc),
    .muteUps(muteUps), .cyc(cyc));

  function automatic bit near(int a, int e, int tol);
    return a >= e - tol && a <= e + tol;
  endfunction

  task automatic close_out;
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [`TPD_ADDR_W-1:0] a, input tpd_nib_t d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [`TPD_ADDR_W-1:0] a, output tpd_nib_t d);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(negedge mclk);
    d = rdData;
  endtask

  task automatic clear;
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
  endtask

  task automatic wait_irq;
    int i;
    for (i = 0; i < 10000 && dialIrq !== 1'b1; i++) @(negedge mclk);
    if (i == 10000) begin
      failures++;
      close_out();
    end
  endtask

  task automatic wait_pulses(input int n, input logic lvl);
    int i;
    for (i = 0; i < 10000 && !(pulses == n && dialPulseOutN === lvl); i++) @(negedge mclk);
    if (i == 10000) begin
      failures++;
      close_out();
    end
  endtask

  task automatic t_reset;
    logic [`TPD_ADDR_W-1:0] a [6] = '{16'hff10, 16'hff15, 16'hff17, 16'hff18, 16'hfff9, 16'hff00};
    tpd_nib_t               e [6] = '{4'h0, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};
    tpd_nib_t               d;
    for (int i = 0; i < 6; i++) begin
      rd(a[i], d);
      `CHK(d, e[i])
    end
    `CHK(dialPulseOutN, 1'b0)
    `CHK(receiveMuteN, 1'b1)
    `CHK(dialIrq, 1'b0)
  endtask

  task automatic t_tone;
    wr(`TPD_ADDR_HOOK, 4'hb);
    // pin is registered behind the hook bit: one more cycle
    repeat (2) @(negedge mclk);
    `CHK(dialPulseOutN, 1'b1)
    clear();
    wr(`TPD_ADDR_DIGIT, 4'h3);
    repeat (400) @(negedge mclk);
    `CHK(pulses, 0)
    `CHK(receiveMuteN, 1'b1)
  endtask

  task automatic t_dial(input tpd_nib_t code, input logic fast, input logic r33, input tpd_nib_t pc);
    int       pps, per, mk, t, i;
    tpd_nib_t d;
    pps = fast ? `TPD_RATE_FAST_PPS : `TPD_RATE_SLOW_PPS;
    per = OSC / pps;
    mk = OSC * (r33 ? `TPD_MAKE33_PERMIL : `TPD_MAKE40_PERMIL) / (pps * `TPD_PERMIL);
    wr(`TPD_ADDR_MODE, {1'b1, fast, r33, 1'b0});
    wr(`TPD_ADDR_PAUSE, pc);
    clear();
    wr(`TPD_ADDR_DIGIT, code);
    @(negedge mclk);
    `CHK(receiveMuteN, 1'b0)
    `CHK(transmitMuteN, 1'b0)
    rd(`TPD_ADDR_IRQ, d);
    `CHK(d, 4'h2)
    wait_irq();
    t = cyc;
    `CHK(pulses, int'(code))
    `CHK(near(breakLen, (per - mk) * TK, 8), 1'b1)
    if (code > 1) `CHK(near(makeLen, mk * TK, 8), 1'b1)
    `CHK(near(t - riseCyc, (mk + pc * STEP) * TK, 12), 1'b1)
    `CHK(dialPulseOutN, 1'b1)
    rd(`TPD_ADDR_IRQ, d);
    `CHK(d[0], 1'b1)
    `CHK(muteUps, 0)
    for (i = 0; i < 100 && receiveMuteN !== 1'b1; i++) @(negedge mclk);
    if (i == 100) begin
      failures++;
      close_out();
    end
    `CHK(near(cyc - t, HOLD * TK, 8), 1'b1)
    `CHK(transmitMuteN, 1'b1)
    wr(`TPD_ADDR_IRQ, 4'h1);
    rd(`TPD_ADDR_IRQ, d);
    `CHK(d[0], 1'b0)
  endtask

  task automatic t_restart;
    wr(`TPD_ADDR_MODE, 4'h8);
    wr(`TPD_ADDR_PAUSE, 4'h1);
    clear();
    wr(`TPD_ADDR_DIGIT, 4'h5);
    wait_pulses(2, 1'b1);
    clear();
    wr(`TPD_ADDR_DIGIT, 4'h3);
    wait_irq();
    `CHK(pulses, 3)
    // next digit lands inside the mute hold
    wr(`TPD_ADDR_IRQ, 4'h1);
    wr(`TPD_ADDR_DIGIT, 4'h1);
    @(negedge mclk);
    `CHK(dialIrq, 1'b0)
    wait_irq();
    `CHK(pulses, 4)
    `CHK(muteUps, 0)
    wr(`TPD_ADDR_IRQ, 4'h1);
  endtask

  task automatic t_abort;
    clear();
    wr(`TPD_ADDR_DIGIT, 4'h9);
    // abort inside a make, so a low pin can only come from going on-hook
    wait_pulses(1, 1'b1);
    wr(`TPD_ADDR_HOOK, 4'h0);
    repeat (2) @(negedge mclk);
    `CHK(dialPulseOutN, 1'b0)
    `CHK(receiveMuteN, 1'b1)
    `CHK(transmitMuteN, 1'b1)
    // long enough for the whole digit and its pause had it not been dropped
    repeat (4000) @(negedge mclk);
    `CHK(dialIrq, 1'b0)
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_tone();
    t_dial(4'h1, 1'b0, 1'b0, 4'h8);
    t_dial(4'ha, 1'b1, 1'b1, 4'h1);
    t_dial(4'hf, 1'b0, 1'b1, 4'hf);
    t_dial(4'h2, 1'b1, 1'b0, 4'h3);
    t_restart();
    t_abort();
    close_out();
  end
endmodule
